// *** logic/eki_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "eki_regs.vh"
module eki_top #(
   parameter KEY_PINS = 6
) (
   input wire mclk,
   input wire rst,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire ext_int_pin_n,
   input wire [KEY_PINS-1:0] keypad_pins_n,
   input wire vector_fetch_ack,
   input wire break_active,
   input wire break_clear_enable,
   output wire ext_irq_req,
   output wire keypad_irq_req,
   output wire [KEY_PINS-1:0] keypad_pullup_en
);
////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers (three stages)
reg [2:0] ext_sync_reg; // External pin sync chain
reg ext_pin_reg; // Filtered external pin level
reg ext_prev_reg; // Previous filtered level
reg [KEY_PINS-1:0] key_s1_reg; // Keypad first stage
reg [KEY_PINS-1:0] key_s2_reg; // Keypad second stage
reg [KEY_PINS-1:0] key_s3_reg; // Keypad third stage
reg [KEY_PINS-1:0] key_pin_reg; // Filtered keypad levels
reg key_any_low_prev_reg; // Previous combined state
// Control state
reg ext_level_sense_sel; // External sensitivity
reg ext_mask_bit; // External mask
reg keypad_level_sense_sel; // Keypad sensitivity
reg keypad_mask_bit; // Keypad mask
reg [KEY_PINS-1:0] keypad_pin_enables; // Keypad pin enables
reg ext_latch_reg; // External request latch
reg key_latch_reg; // Keypad request latch
reg ext_ack_mem_reg; // External acknowledge seen while pin low
reg key_ack_mem_reg; // Keypad acknowledge seen while pins low
// Combinational terms
wire key_any_low; // Some enabled pin low
wire ext_fall; // External falling edge
wire key_fall; // Combined keypad falling edge
wire scr_wr; // Status/control write
wire ack_ok; // Software acknowledge allowed
wire ext_sw_ack; // External software acknowledge
wire key_sw_ack; // Keypad software acknowledge
wire ext_clear; // External clear condition
wire key_clear; // Keypad clear condition
wire ext_ack; // Any external acknowledge
wire key_ack; // Any keypad acknowledge
wire ext_set; // External set condition
wire key_set; // Keypad set condition
////////////////////////////////////////////////////////////////////////////////
// Sample pins; a level counts once stages two and three agree
always @(posedge mclk)
begin
   if (rst)
   begin
      ext_sync_reg <= 3'h7;
      ext_pin_reg <= 1'h1;
      ext_prev_reg <= 1'h1;
      key_s1_reg <= {KEY_PINS{1'b1}};
      key_s2_reg <= {KEY_PINS{1'b1}};
      key_s3_reg <= {KEY_PINS{1'b1}};
      key_pin_reg <= {KEY_PINS{1'b1}};
      key_any_low_prev_reg <= 1'h0;
   end
   else
   begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_int_pin_n};
      if (ext_sync_reg[1] == ext_sync_reg[2])
      begin
         ext_pin_reg <= ext_sync_reg[2];
      end
      ext_prev_reg <= ext_pin_reg;
      key_s1_reg <= keypad_pins_n;
      key_s2_reg <= key_s1_reg;
      key_s3_reg <= key_s2_reg;
      // Per pin agreement of stages two and three
      key_pin_reg <= (key_s2_reg & key_s3_reg) | (key_pin_reg & (key_s2_reg | key_s3_reg));
      key_any_low_prev_reg <= key_any_low;
   end
end
////////////////////////////////////////////////////////////////////////////////
// Edge and level decode
assign key_any_low = |(~key_pin_reg & keypad_pin_enables);
assign ext_fall = ext_prev_reg & ~ext_pin_reg;
assign key_fall = key_any_low & ~key_any_low_prev_reg;
assign scr_wr = reg_wr && (reg_addr == `EKI_ADDR_SCR);
assign ack_ok = ~break_active | break_clear_enable;
assign ext_sw_ack = scr_wr & reg_wdata[`EKI_EXT_ACK_BIT] & ack_ok;
assign key_sw_ack = scr_wr & reg_wdata[`EKI_KEY_ACK_BIT] & ack_ok;
assign ext_ack = vector_fetch_ack | ext_sw_ack;
assign key_ack = vector_fetch_ack | key_sw_ack;
// Level mode also sets on a low level
assign ext_set = ext_fall | (ext_level_sense_sel & ~ext_pin_reg);
assign key_set = key_fall | (keypad_level_sense_sel & key_any_low);
// Level mode holds while the pin stays low; an earlier acknowledge still counts
assign ext_clear = (ext_ack | ext_ack_mem_reg) &
                   ~(ext_level_sense_sel & ~ext_pin_reg);
assign key_clear = (key_ack | key_ack_mem_reg) &
                   ~(keypad_level_sense_sel & key_any_low);
////////////////////////////////////////////////////////////////////////////////
// Remember an acknowledge given while a level request is still held low
always @(posedge mclk)
begin
   if (rst)
   begin
      ext_ack_mem_reg <= 1'h0;
      key_ack_mem_reg <= 1'h0;
   end
   else
   begin
      // A new edge or an idle latch forgets the acknowledge
      if (ext_fall | ~ext_latch_reg)
      begin
         ext_ack_mem_reg <= 1'h0;
      end
      else if (ext_ack & ext_level_sense_sel & ~ext_pin_reg)
      begin
         ext_ack_mem_reg <= 1'h1;
      end
      if (key_fall | ~key_latch_reg)
      begin
         key_ack_mem_reg <= 1'h0;
      end
      else if (key_ack & keypad_level_sense_sel & key_any_low)
      begin
         key_ack_mem_reg <= 1'h1;
      end
   end
end
////////////////////////////////////////////////////////////////////////////////
// Request latches; a new edge wins over an acknowledge
always @(posedge mclk)
begin
   if (rst)
   begin
      ext_latch_reg <= 1'h0;
      key_latch_reg <= 1'h0;
   end
   else
   begin
      if (ext_set)
      begin
         ext_latch_reg <= 1'h1;
      end
      else if (ext_clear)
      begin
         ext_latch_reg <= 1'h0;
      end
      if (key_set)
      begin
         key_latch_reg <= 1'h1;
      end
      else if (key_clear)
      begin
         key_latch_reg <= 1'h0;
      end
   end
end
////////////////////////////////////////////////////////////////////////////////
// Register writes
always @(posedge mclk)
begin
   if (rst)
   begin
      ext_level_sense_sel <= 1'h0;
      ext_mask_bit <= 1'h0;
      keypad_level_sense_sel <= 1'h0;
      keypad_mask_bit <= 1'h0;
      keypad_pin_enables <= `EKI_KEN_RESET;
   end
   else if (reg_wr)
   begin
      case (reg_addr)
         `EKI_ADDR_SCR:
         begin
            ext_level_sense_sel <= reg_wdata[`EKI_EXT_LEVEL_BIT];
            ext_mask_bit <= reg_wdata[`EKI_EXT_MASK_BIT];
            keypad_level_sense_sel <= reg_wdata[`EKI_KEY_LEVEL_BIT];
            keypad_mask_bit <= reg_wdata[`EKI_KEY_MASK_BIT];
         end
         `EKI_ADDR_KEN:
         begin
            keypad_pin_enables <= reg_wdata[KEY_PINS-1:0];
         end
         default:
         begin
            keypad_pin_enables <= keypad_pin_enables;
         end
      endcase
   end
end
////////////////////////////////////////////////////////////////////////////////
// Register reads, data one cycle after the strobe
always @(posedge mclk)
begin
   if (rst)
   begin
      reg_rdata <= 8'h00;
   end
   else if (reg_rd)
   begin
      case (reg_addr)
         `EKI_ADDR_SCR:
         begin
            // Acknowledge bits read zero
            reg_rdata <= {ext_latch_reg | key_latch_reg ? 8'h00 : 8'h00} |
                         ({7'h00, key_latch_reg} << `EKI_KEY_PEND_BIT) |
                         ({7'h00, keypad_mask_bit} << `EKI_KEY_MASK_BIT) |
                         ({7'h00, keypad_level_sense_sel} << `EKI_KEY_LEVEL_BIT) |
                         ({7'h00, ext_latch_reg} << `EKI_EXT_PEND_BIT) |
                         ({7'h00, ext_mask_bit} << `EKI_EXT_MASK_BIT) |
                         ({7'h00, ext_level_sense_sel} << `EKI_EXT_LEVEL_BIT);
         end
         `EKI_ADDR_KEN:
         begin
            reg_rdata <= {{(8-KEY_PINS){1'b0}}, keypad_pin_enables};
         end
         default:
         begin
            reg_rdata <= 8'h00;
         end
      endcase
   end
   else
   begin
      reg_rdata <= 8'h00;
   end
end
////////////////////////////////////////////////////////////////////////////////
// Outputs to the CPU priority logic and pin pullups
assign ext_irq_req = ext_latch_reg & ~ext_mask_bit;
assign keypad_irq_req = key_latch_reg & ~keypad_mask_bit;
assign keypad_pullup_en = keypad_pin_enables;
endmodule
`default_nettype wire

// *** shared/eki_regs.vh ***
// What this block does
// - Low external pin can set its latch
// - Vector fetch acknowledge clears both latches
// - External acknowledge write clears external latch
// - Keypad acknowledge write clears keypad latch
// - Reset clears latches and sensitivity bits
// - Edge-only or edge-plus-level per source
// - Edge mode: latch holds until acknowledge
// - Level mode: needs acknowledge and pin high
// - Mask blocks forwarding, latch keeps state
// - Edge after acknowledge sets latch again
// - External pending flag ignores mask
// - Break with clear disabled blocks acknowledge writes, not vector fetch
// - Break clear enabled lets acknowledges clear
// - Six keypad enables, also drive pullups
// - One keypad latch, one keypad mask
// - Latch when enabled pin falls after all high
// - Edge mode: no latch if another low
// - Level mode: request while any enabled pin low
// - Acknowledge bits always read zero
// - Keypad pending flag ignores mask
`ifndef EKI_REGS_VH
`define EKI_REGS_VH
// Register offsets
`define EKI_ADDR_SCR 4'h0
`define EKI_ADDR_KEN 4'h1
// Status and control register fields
`define EKI_EXT_LEVEL_BIT 0
`define EKI_EXT_MASK_BIT 1
`define EKI_EXT_ACK_BIT 2
`define EKI_EXT_PEND_BIT 3
`define EKI_KEY_LEVEL_BIT 4
`define EKI_KEY_MASK_BIT 5
`define EKI_KEY_ACK_BIT 6
`define EKI_KEY_PEND_BIT 7
// Reset values
`define EKI_SCR_RESET 4'h0
`define EKI_KEN_RESET 6'h00
`endif

// *** tb/eki_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Pin side: pulled-up external source and keypad switches to ground
module eki_pin_model (
   input wire logic mclk,
   input wire logic ext_low,
   input wire logic [5:0] key_low,
   input wire logic [5:0] keypad_pullup_en,
   output logic ext_int_pin_n,
   output logic [5:0] keypad_pins_n
);
   logic tog = 1'b0;
   // A pin without its pullup floats and wanders every cycle
   always @(posedge mclk) tog <= ~tog;
   assign ext_int_pin_n = ~ext_low;
   assign keypad_pins_n = ~key_low & (keypad_pullup_en | {6{tog}});
endmodule
`default_nettype wire

// *** tb/eki_top_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the latch block
module eki_top_monitor #(parameter KEY_PINS = 6) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic ext_int_pin_n,
   input wire logic [KEY_PINS-1:0] keypad_pins_n,
   input wire logic vector_fetch_ack,
   input wire logic ext_irq_req,
   input wire logic keypad_irq_req,
   input wire logic [KEY_PINS-1:0] keypad_pullup_en
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_rdata_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   property p_ack_zero; reg_rd && reg_addr == 4'h0 |=> !reg_rdata[2] && !reg_rdata[6]; endproperty
   a_ack_zero: assert property (p_ack_zero) else $error("ack bit read back");
   property p_ext_flag; reg_rd && reg_addr == 4'h0 && ext_irq_req |=> reg_rdata[3]; endproperty
   a_ext_flag: assert property (p_ext_flag) else $error("pending flag low");
   property p_pullup; !(reg_wr && reg_addr == 4'h1) |=> $stable(keypad_pullup_en); endproperty
   a_pullup: assert property (p_pullup) else $error("pullups moved");
   property p_ext_hold;
      (!ext_int_pin_n) [*6] ##0 (ext_irq_req && !vector_fetch_ack && !reg_wr) |=> ext_irq_req;
   endproperty
   a_ext_hold: assert property (p_ext_hold) else $error("ext request lost");
   property p_key_hold;
      (|(~keypad_pins_n & keypad_pullup_en)) [*6] ##0
      (keypad_irq_req && !vector_fetch_ack && !reg_wr) |=> keypad_irq_req;
   endproperty
   a_key_hold: assert property (p_key_hold) else $error("key request lost");
   property p_ext_vec; ext_int_pin_n [*8] ##0 vector_fetch_ack |=> !ext_irq_req; endproperty
   a_ext_vec: assert property (p_ext_vec) else $error("ext not cleared");
   property p_key_vec;
      (&(keypad_pins_n | ~keypad_pullup_en)) [*8] ##0 vector_fetch_ack |=> !keypad_irq_req;
   endproperty
   a_key_vec: assert property (p_key_vec) else $error("key not cleared");
endmodule
bind eki_top eki_top_monitor #(.KEY_PINS(KEY_PINS)) i_eki_top_monitor (.*);
`default_nettype wire

// *** tb/eki_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module eki_top_test;
   logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, vector_fetch_ack = 1'b0;
   logic break_active = 1'b0, break_clear_enable = 1'b0, ext_low = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [5:0] key_low = 6'h00;
   wire [7:0] reg_rdata;
   wire ext_int_pin_n, ext_irq_req, keypad_irq_req;
   wire [5:0] keypad_pins_n, keypad_pullup_en;
   int err_total = 0;
   int comparisons = 0;
   always #50 mclk = ~mclk;
   eki_top #(.KEY_PINS(6)) i_eki_top (.*);
   eki_pin_model i_eki_pin_model (.*);
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      check(reg_rdata, e);
      @(posedge mclk);
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic vfa();
      vector_fetch_ack <= 1'b1;
      @(posedge mclk);
      vector_fetch_ack <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic complete_run();
      if (err_total == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Watchdog far beyond the roughly 140 cycles of the sequence
   initial
   begin
      #200000;
      err_total++;
      complete_run();
   end
   initial
   begin
      waitc(8);
      rst <= 1'b0;
      waitc(1);
      rd(4'h0, 8'h00);
      rd(4'h2, 8'h00);
      ext_low <= 1'b1;
      waitc(8);
      rd(4'h0, 8'h08);
      check({7'h00, ext_irq_req}, 8'h01);
      wr(4'h0, 8'h02);
      rd(4'h0, 8'h0a);
      check({7'h00, ext_irq_req}, 8'h00);
      wr(4'h0, 8'h04);
      rd(4'h0, 8'h00);
      ext_low <= 1'b0;
      waitc(8);
      ext_low <= 1'b1;
      waitc(8);
      break_active <= 1'b1;
      wr(4'h0, 8'h04);
      rd(4'h0, 8'h08);
      break_clear_enable <= 1'b1;
      wr(4'h0, 8'h04);
      break_active <= 1'b0;
      rd(4'h0, 8'h00);
      wr(4'h0, 8'h01);
      vfa();
      rd(4'h0, 8'h09);
      wr(4'h0, 8'h03);
      check({7'h00, ext_irq_req}, 8'h00);
      wr(4'h0, 8'h01);
      ext_low <= 1'b0;
      waitc(8);
      rd(4'h0, 8'h01);
      vfa();
      rd(4'h0, 8'h01);
      wr(4'h1, 8'h03);
      waitc(8);
      wr(4'h0, 8'h40);
      check({2'b00, keypad_pullup_en}, 8'h03);
      key_low <= 6'h01;
      waitc(8);
      rd(4'h0, 8'h80);
      wr(4'h0, 8'h40);
      key_low <= 6'h23;
      waitc(8);
      rd(4'h0, 8'h00);
      wr(4'h0, 8'h10);
      rd(4'h0, 8'h90);
      key_low <= 6'h20;
      waitc(8);
      vfa();
      rd(4'h0, 8'h10);
      key_low <= 6'h01;
      waitc(8);
      rst <= 1'b1;
      waitc(1);
      rst <= 1'b0;
      waitc(1);
      rd(4'h0, 8'h00);
      complete_run();
   end
endmodule
`default_nettype wire
